// File: hw/bcc_defines.vh
// Purpose: Constants for the buck converter control register bank
// Assumes: Byte-wide register port, 25 MHz system clock
// Notes: Offsets are register indices on the device's byte port
`ifndef BCC_DEFINES_VH
`define BCC_DEFINES_VH
`define BCC_OFS_BUCK1 8'h00
`define BCC_OFS_BUCK2 8'h01
`define BCC_OFS_BUCK3 8'h02
`define BCC_OFS_BUCK4 8'h03
`define BCC_UNMAPPED_DATA 8'hff
`define BCC_BIT_PIN_SEL 7
`define BCC_RANGE_HI 6
`define BCC_RANGE_LO 5
`define BCC_STEP_HI 4
`define BCC_STEP_LO 2
`define BCC_BIT_PWM 1
`define BCC_BIT_RAMP 0
`define BCC_STEP_RESET 3'h0
`define BCC_RANGE_FORCED 2'h0
`define BCC_CLK_MHZ 25
`define BCC_RAMP_SLOW_US 200
`define BCC_RAMP_FAST_US 60
`define BCC_RAMP_SLOW_CYC (`BCC_RAMP_SLOW_US * `BCC_CLK_MHZ)
`define BCC_RAMP_FAST_CYC (`BCC_RAMP_FAST_US * `BCC_CLK_MHZ)
`define BCC_SLEW_TICK_CYC 16'd25
`endif

// File: hw/bcc_regs.v
// Purpose: Control registers for four step-down converters
// Assumes: Byte register port on the system clock; OTP defaults valid at
//          reset release
// Notes: The buck1 target steps one code per slew tick toward the requested code
//        Ramp acts only at start-up and takes its length from the OTP ramp bit; register writes never change it
`timescale 1ns/1ps
`include "bcc_defines.vh"
// Contract
// - Select clear: target from registers or pin
// - Select set: target from two scaling pins
// - Pin scaling forces range 00, ignores register codes; register range field sets pin code top
// - Range 00 spans 24 steps of 25 mV
// - Other ranges give 32 steps, 12.5 mV
// - Step time field paces intermediate voltage steps
// - Mode bit forces PWM when set
// - Ramp bit picks slow or fast start ramp
// - Registers return to defaults on reset
// - Programmable fields except step time load defaults from OTP
// - Unmapped reads return all ones
module bcc_regs (
   input wire i_clk_sys,
   input wire i_resetn,
   input wire i_wr_en,
   input wire i_rd_en,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   output reg [7:0] o_rdata,
   input wire [7:0] i_otp_buck1,
   input wire [7:0] i_otp_buck2,
   input wire [7:0] i_otp_buck3,
   input wire [7:0] i_otp_buck4,
   input wire i_scaling_level_pin,
   input wire i_scaling_clock_pin,
   input wire i_buck1_voltage_select_pin,
   input wire [5:0] i_buck1_reg_code,
   input wire [5:0] i_buck1_alt_code,
   output reg [5:0] o_buck1_target,
   output reg [1:0] o_buck1_range,
   output reg o_buck1_pin_mode,
   output reg [3:0] o_pwm_force,
   output reg o_buck4_ramp_busy
);
   localparam ST_LOAD = 3'b001;
   localparam ST_RUN = 3'b010;
   localparam ST_IDLE = 3'b100;
   reg [2:0] state_reg;
   reg [7:0] ctl_reg [0:3];
   reg [5:0] pin_code_reg;
   reg clk_pin_d_reg;
   reg [5:0] goal;
   reg [15:0] tick_cnt_reg;
   reg [18:0] ramp_cnt_reg;
   wire lvl_s;
   wire clk_s;
   wire sel_s;
   wire [15:0] tick_len;
   wire [5:0] pin_max;
   integer k;
   genvar g;
   // Ramp lengths are whole cycles of the system clock
   wire [31:0] ramp_fast = `BCC_RAMP_FAST_CYC;
   wire [31:0] ramp_slow = `BCC_RAMP_SLOW_CYC;
   // Writes in the load cycle are dropped so they cannot override the OTP copy
   wire wr_ok = i_wr_en && (state_reg != ST_LOAD);
   reg [7:0] rdata_next;
   wire [3:0] pwm_sel;

   // Pins are asynchronous, so each passes two flops first
   bcc_sync u_sync_lvl (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
      .i_pin(i_scaling_level_pin), .o_level(lvl_s));
   bcc_sync u_sync_clk (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
      .i_pin(i_scaling_clock_pin), .o_level(clk_s));
   bcc_sync u_sync_sel (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
      .i_pin(i_buck1_voltage_select_pin), .o_level(sel_s));

   // One force bit per converter, bit k for converter k+1
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_pwm
         assign pwm_sel[g] = ctl_reg[g][`BCC_BIT_PWM];
      end
   endgenerate

   // Pin scaling fields live only in the first register
   wire pin_mode = ctl_reg[0][`BCC_BIT_PIN_SEL];
   wire [1:0] pin_rng = ctl_reg[0][`BCC_RANGE_HI:`BCC_RANGE_LO];
   wire [2:0] step1 = ctl_reg[0][`BCC_STEP_HI:`BCC_STEP_LO];
   // Range 00 has 24 codes, the others 32
   assign pin_max = (pin_rng == 2'h0) ? 6'd23 : 6'd31;
   // Slew tick grows with step time code
   assign tick_len = `BCC_SLEW_TICK_CYC << step1;
   // Only a rising edge of the synced clock pin steps the code; a smaller range clamps it to pin_max
   wire clk_rise = clk_s && !clk_pin_d_reg;
   wire slew_tick = (tick_cnt_reg >= tick_len - 16'h0001);

   // Pin code replaces both register and select pin sources
   always @* begin
      if (pin_mode) begin
         goal = pin_code_reg;
      end else if (sel_s) begin
         goal = i_buck1_alt_code;
      end else begin
         goal = i_buck1_reg_code;
      end
   end

   // Unmapped offsets answer all ones
   always @* begin
      if (i_addr == `BCC_OFS_BUCK1) begin
         rdata_next = ctl_reg[0];
      end else if (i_addr == `BCC_OFS_BUCK2) begin
         rdata_next = ctl_reg[1];
      end else if (i_addr == `BCC_OFS_BUCK3) begin
         rdata_next = ctl_reg[2];
      end else if (i_addr == `BCC_OFS_BUCK4) begin
         rdata_next = ctl_reg[3];
      end else begin
         rdata_next = `BCC_UNMAPPED_DATA;
      end
   end

   // Reset holds plain zeros; OTP values arrive one edge later
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg <= ST_LOAD;
         for (k = 0; k < 4; k = k + 1) begin
            ctl_reg[k] <= 8'h00;
         end
         o_rdata <= 8'h00;
         pin_code_reg <= 6'h00;
         clk_pin_d_reg <= 1'b0;
         tick_cnt_reg <= 16'h0000;
         ramp_cnt_reg <= 19'h00000;
         o_buck1_target <= 6'h00;
         o_buck1_range <= 2'h0;
         o_buck1_pin_mode <= 1'b0;
         o_pwm_force <= 4'h0;
         o_buck4_ramp_busy <= 1'b0;
      end else begin
         clk_pin_d_reg <= clk_s;
         case (state_reg)
            ST_LOAD: begin
               // OTP captured after release, never inside reset
               ctl_reg[0] <= {i_otp_buck1[7:5], `BCC_STEP_RESET,
                  i_otp_buck1[1], 1'b0};
               ctl_reg[1] <= {3'h0, `BCC_STEP_RESET, i_otp_buck2[1],
                  1'b0};
               ctl_reg[2] <= {3'h0, `BCC_STEP_RESET, i_otp_buck3[1],
                  1'b0};
               ctl_reg[3] <= {3'h0, `BCC_STEP_RESET, i_otp_buck4[1],
                  i_otp_buck4[0]};
               ramp_cnt_reg <= i_otp_buck4[`BCC_BIT_RAMP] ?
                  ramp_fast[18:0] : ramp_slow[18:0];
               o_buck4_ramp_busy <= 1'b1;
               state_reg <= ST_RUN;
            end
            ST_RUN: begin
               // Busy drops on the edge after the count reaches one
               if (ramp_cnt_reg > 19'h00001) begin
                  ramp_cnt_reg <= ramp_cnt_reg - 19'h00001;
               end else begin
                  o_buck4_ramp_busy <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               // Ramp runs once per reset from the OTP ramp bit, so a rewritten
               // register ramp bit never changes the ramp length
               state_reg <= ST_IDLE;
            end
            default: begin
               // Any stray code restarts the OTP load
               state_reg <= ST_LOAD;
            end
         endcase
         if (wr_ok) begin
            // Reserved positions are masked so they always read zero
            if (i_addr == `BCC_OFS_BUCK1) begin
               ctl_reg[0] <= {i_wdata[7:1], 1'b0};
            end else if (i_addr == `BCC_OFS_BUCK2) begin
               ctl_reg[1] <= {3'h0, i_wdata[4:1], 1'b0};
            end else if (i_addr == `BCC_OFS_BUCK3) begin
               ctl_reg[2] <= {3'h0, i_wdata[4:1], 1'b0};
            end else if (i_addr == `BCC_OFS_BUCK4) begin
               ctl_reg[3] <= {3'h0, i_wdata[4:0]};
            end
         end
         // Read data holds until the next read
         if (i_rd_en) begin
            o_rdata <= rdata_next;
         end
         // Scaling clock rising edge moves code up or down by level pin
         if (!pin_mode) begin
            pin_code_reg <= 6'h00;
         end else if (clk_rise) begin
            if (lvl_s && pin_code_reg < pin_max) begin
               pin_code_reg <= pin_code_reg + 6'h01;
            end else if (!lvl_s && pin_code_reg != 6'h00) begin
               pin_code_reg <= pin_code_reg - 6'h01;
            end
         end else if (pin_code_reg > pin_max) begin
            pin_code_reg <= pin_max;
         end
         // Target walks one code per tick instead of jumping
         if (slew_tick) begin
            tick_cnt_reg <= 16'h0000;
            if (o_buck1_target < goal) begin
               o_buck1_target <= o_buck1_target + 6'h01;
            end else if (o_buck1_target > goal) begin
               o_buck1_target <= o_buck1_target - 6'h01;
            end
         end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
         end
         o_buck1_pin_mode <= pin_mode;
         // Range is held at 00 while the pins own the target
         o_buck1_range <= pin_mode ? `BCC_RANGE_FORCED : pin_rng;
         o_pwm_force <= pwm_sel;
      end
   end
endmodule // bcc_regs

// File: hw/bcc_sync.v
// Purpose: Two-flop synchroniser for a pin level
// Assumes: One clock domain
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module bcc_sync (
   input wire i_clk_sys,
   input wire i_resetn,
   input wire i_pin,
   output reg o_level
);
   reg meta_reg;
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         meta_reg <= 1'b0;
         o_level <= 1'b0;
      end else begin
         meta_reg <= i_pin;
         o_level <= meta_reg;
      end
   end
endmodule // bcc_sync

// File: testbench/bcc_host.sv
// Purpose: Host model on the register byte port
// Assumes: One strobe cycle per transfer
// Notes: Reserved bits always go out as zero
`timescale 1ns/1ps
module bcc_host (
   input wire i_clk_sys,
   output logic o_wr_en = 1'b0,
   output logic o_rd_en = 1'b0,
   output logic [7:0] o_addr = 8'h0,
   output logic [7:0] o_wdata = 8'h0
);
   task automatic xfer(input bit wr, input logic [7:0] a,
      input logic [7:0] d);
      @(posedge i_clk_sys);
      o_wr_en <= wr;
      o_rd_en <= !wr;
      o_addr <= a;
      o_wdata <= d & (a == 8'h0 ? 8'hfe : (a == 8'h3 ? 8'h1f : 8'h1e));
      @(posedge i_clk_sys);
      o_wr_en <= 1'b0;
      o_rd_en <= 1'b0;
   endtask
endmodule // bcc_host

// File: testbench/bcc_regs_monitor.sv
// Purpose: Port assertions for bcc_regs
// Assumes: Bound to bcc_regs
// Notes: Ramp too long to repeat, so it is counted
`timescale 1ns/1ps
module bcc_regs_monitor (
   input wire i_clk_sys,
   input wire i_resetn,
   input wire i_wr_en,
   input wire i_rd_en,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire [7:0] o_rdata,
   input wire [5:0] o_buck1_target,
   input wire [1:0] o_buck1_range,
   input wire o_buck1_pin_mode,
   input wire [3:0] o_pwm_force,
   input wire o_buck4_ramp_busy
);
   reg [12:0] busy_cnt_reg;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   always @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn)
         busy_cnt_reg <= 13'h0;
      else if (o_buck4_ramp_busy)
         busy_cnt_reg <= busy_cnt_reg + 13'h1;
   end
   a_range_forced: assert property (
      o_buck1_pin_mode |-> o_buck1_range == 2'h0) else $error("range");
   a_unmapped_ones: assert property (
      i_rd_en && i_addr > 8'h03 |=> o_rdata == 8'hff) else $error("ff");
   a_upper_reserved: assert property (
      i_rd_en && i_addr inside {[8'h01:8'h03]} |=> o_rdata[7:5] == 3'h0)
      else $error("upper");
   a_low_reserved: assert property (
      i_rd_en && i_addr < 8'h03 |=> o_rdata[0] == 1'b0) else $error("bit0");
   a_mode_follows: assert property (
      i_wr_en && i_addr == 8'h01 && $past(i_resetn) |->
      ##2 o_pwm_force[1] == $past(i_wdata[1], 2)) else $error("mode");
   a_pin_follows: assert property (
      i_wr_en && i_addr == 8'h00 && $past(i_resetn) |->
      ##2 o_buck1_pin_mode == $past(i_wdata[7], 2)) else $error("pin");
   a_ramp_length: assert property ($fell(o_buck4_ramp_busy) |->
      busy_cnt_reg == 13'd1500 || busy_cnt_reg == 13'd5000)
      else $error("ramp");
   a_step_paced: assert property ($changed(o_buck1_target) |=>
      $stable(o_buck1_target)[*8]) else $error("pace");
endmodule // bcc_regs_monitor
bind bcc_regs bcc_regs_monitor mon_u (.i_clk_sys(i_clk_sys),
   .i_resetn(i_resetn), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
   .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
   .o_buck1_target(o_buck1_target), .o_buck1_range(o_buck1_range),
   .o_buck1_pin_mode(o_buck1_pin_mode), .o_pwm_force(o_pwm_force),
   .o_buck4_ramp_busy(o_buck4_ramp_busy));

// File: testbench/testbench.sv
// Purpose: Self-checking bench for bcc_regs
// Assumes: Host model owns the byte port
// Notes: Step time resets to zero, OTP seeds the rest
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, rstn = 1'b0, lvl = 1'b0, sck = 1'b0, vsel = 1'b0;
   logic [5:0] rcode = 6'h0, acode = 6'h0, tgt;
   logic [7:0] otp [4] = '{default: 8'h0};
   logic [7:0] keep [4] = '{8'hfe, 8'h1e, 8'h1e, 8'h1f};
   logic [7:0] wv [4];
   logic [7:0] addr, wdata, rdata, exp_q [$];
   logic [1:0] range;
   logic rd_pipe = 1'b0;
   logic [15:0] busy_cycles = 16'h0;
   logic [3:0] pwm;
   logic wr_en, rd_en, pin_mode, busy;
   int fail_count = 0, comparisons = 0;
   always #20 clk = ~clk;
   bcc_host host_u (.i_clk_sys(clk), .o_wr_en(wr_en), .o_rd_en(rd_en),
      .o_addr(addr), .o_wdata(wdata));
   bcc_regs dut_u (.i_clk_sys(clk), .i_resetn(rstn), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
      .i_otp_buck1(otp[0]), .i_otp_buck2(otp[1]), .i_otp_buck3(otp[2]),
      .i_otp_buck4(otp[3]), .i_scaling_level_pin(lvl),
      .i_scaling_clock_pin(sck), .i_buck1_voltage_select_pin(vsel),
      .i_buck1_reg_code(rcode), .i_buck1_alt_code(acode),
      .o_buck1_target(tgt), .o_buck1_range(range),
      .o_buck1_pin_mode(pin_mode), .o_pwm_force(pwm),
      .o_buck4_ramp_busy(busy));
   task automatic cmp(input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic cmp_cycles(input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic rd(input int a, input logic [7:0] e);
      exp_q.push_back(e);
      host_u.xfer(1'b0, 8'(a), 8'h0);
   endtask
   task automatic boot;
      @(posedge clk);
      rstn <= 1'b0;
      foreach (otp[i]) otp[i] <= 8'($urandom);
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 4; i++)
         rd(i, otp[i] & keep[i] & 8'he3);
   endtask
   // Read data stands from the edge after the strobe; compare one edge
   // later, before a following read can replace it
   always @(posedge clk) begin
      if (rd_pipe)
         cmp(exp_q.pop_front(), rdata);
      rd_pipe <= rd_en;
   end
   // Cycles of start ramp seen since the last reset
   always @(posedge clk) begin
      if (!rstn)
         busy_cycles <= 16'h0;
      else if (busy)
         busy_cycles <= busy_cycles + 16'h1;
   end
   task automatic report_and_stop;
      if (fail_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #800000;
      fail_count++;
      report_and_stop;
   end
   initial begin
      void'($urandom(10));
      boot;
      rd(4 + $urandom % 252, 8'hff);
      for (int i = 0; i < 4; i++) begin
         wv[i] = 8'($urandom);
         host_u.xfer(1'b1, 8'(i), wv[i]);
      end
      for (int i = 0; i < 4; i++)
         rd(i, wv[i] & keep[i]);
      cmp(8'({wv[3][1], wv[2][1], wv[1][1], wv[0][1]}), 8'(pwm));
      // Step time 0 keeps the slew walk short
      wv[0] = 8'h80 | (8'($urandom) & 8'h62);
      host_u.xfer(1'b1, 8'h00, wv[0]);
      repeat (40) begin
         @(posedge clk);
         sck <= ~sck;
         {lvl, vsel, rcode, acode} <= 14'($urandom);
      end
      cmp(8'(range), 8'h00);
      // Forty up steps saturate the pin code at the table's top
      @(posedge clk);
      {lvl, sck} <= 2'b10;
      repeat (80) begin
         repeat (2) @(posedge clk);
         sck <= ~sck;
      end
      repeat (1000) @(posedge clk);
      cmp(8'(tgt), wv[0][6:5] == 2'h0 ? 8'd23 : 8'd31);
      {vsel, rcode} <= {1'b0, 6'($urandom)};
      host_u.xfer(1'b1, 8'h00, 8'h00);
      repeat (2000) @(posedge clk);
      cmp(8'(tgt), 8'(rcode));
      {vsel, acode} <= {1'b1, 6'($urandom)};
      repeat (2000) @(posedge clk);
      cmp(8'(tgt), 8'(acode));
      boot;
      for (int n = 0; n < 6000 && busy !== 1'b0; n++)
         @(posedge clk);
      cmp(8'(busy), 8'h00);
      // Fast ramp 60 us, slow 200 us, at 25 cycles per us
      cmp_cycles(otp[3][0] ? 16'd1500 : 16'd5000, busy_cycles);
      repeat (3) @(posedge clk);
      report_and_stop;
   end
endmodule // testbench
